// ==== led_current_sink_sequencer.sv ====
// three-channel LED current sink driver with register port and flash sequencer
// assumes synchronous inputs, 100 MHz clk, an analog sink per pin taking a 4-bit code
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "led_defs.svh"

module led_current_sink_sequencer #(
    parameter logic [19:0] TICK_CYCLES = 20'(`TICK_CYCLES)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic [2:0] gpioData,
    output logic [2:0] pinDrive,
    output logic [2:0] pinSinkMode,
    output logic [2:0] pinSinkOn,
    output led_pkg::code_array_t pinSinkCode
);
    import led_pkg::*;

    top_s r;
    top_s next_r;
    logic [2:0] chLit;
    logic [2:0][3:0] chLevel;
    logic [2:0][2:0] chSlot;
    logic [2:0] chSinkOn;

    led_channel_if chIf[3] ();

    // ************************************************
    // channels
    // ************************************************
    for (genvar i = 0; i < 3; i++) begin : gen_ch
        assign chIf[i].enable = r.pinSelect[i] && r.sinkEnable[i];
        assign chIf[i].run = r.pinSelect[i] && r.sinkEnable[i] && r.flashEnable[i];
        assign chIf[i].tick = r.tick;
        assign chIf[i].rampSelect = r.rampSelect[i];
        // codes above 20 mA are held at 20 mA
        assign chIf[i].target = (r.current[i] > `CURRENT_MAX) ? `CURRENT_MAX : r.current[i];
        assign chIf[i].duty = r.duty[i];
        assign chIf[i].pwmCount = r.pwmCount;
        assign chIf[i].rampUp = r.rampUp;
        assign chIf[i].rampDown = r.rampDown;
        assign chIf[i].onDuration = r.onDuration[i];
        assign chIf[i].slotLength = r.slotLength[i];
        assign chLit[i] = chIf[i].lit;
        assign chLevel[i] = chIf[i].level;
        assign chSlot[i] = chIf[i].slot;
        assign chSinkOn[i] = chIf[i].sinkOn;

        led_channel u_channel (
            .clk(clk),
            .reset(reset),
            .ch(chIf[i])
        );
    end

    // ************************************************
    // registers, timebase and read port
    // ************************************************
    always_comb begin
        logic [3:0] block;
        logic [3:0] field;
        logic [1:0] led;
        block = regAddr[7:4];
        field = regAddr[3:0];
        led = 2'(block - `LED_BLOCK_FIRST);
        next_r = r;

        // 8 ms tick for ramps, on-time and slots
        next_r.tick = 1'b0;
        if (r.tickCount >= TICK_CYCLES - 20'h00001) begin
            next_r.tickCount = 20'h00000;
            next_r.tick = 1'b1;
        end else begin
            next_r.tickCount = r.tickCount + 20'h00001;
        end

        // PWM frame of 31 steps
        if (r.pwmDiv >= 4'(`PWM_STEP_CYCLES - 1)) begin
            next_r.pwmDiv = 4'h0;
            next_r.pwmCount = (r.pwmCount >= `PWM_LAST) ? 5'h00 : r.pwmCount + 5'h01;
        end else begin
            next_r.pwmDiv = r.pwmDiv + 4'h1;
        end

        // a pin in sink mode drops its general-purpose drive
        next_r.pinDrive = gpioData & ~r.pinSelect;

        if (regWrite) begin
            if (regAddr == `REG_PIN_SELECT) begin
                // mixed settings are accepted; software keeps the three alike
                next_r.pinSelect = regWriteData[2:0];
            end else if (regAddr == `REG_SEQ_ENABLE) begin
                next_r.sinkEnable = regWriteData[2:0];
                next_r.flashEnable = regWriteData[`SEQ_FLASH_LSB +: 3];
            end else if (regAddr == `REG_RAMP_UP) begin
                next_r.rampUp = regWriteData[4:0];
            end else if (regAddr == `REG_RAMP_DOWN) begin
                next_r.rampDown = regWriteData[4:0];
            end else if (block >= `LED_BLOCK_FIRST && block <= `LED_BLOCK_LAST) begin
                if (field == `LED_CURRENT) begin
                    next_r.current[led] = regWriteData[3:0];
                end else if (field == `LED_DUTY) begin
                    next_r.duty[led] = regWriteData[4:0];
                end else if (field == `LED_RAMP) begin
                    next_r.rampSelect[led] = regWriteData[0];
                end else if (field == `LED_ON) begin
                    next_r.onDuration[led] = regWriteData;
                end else if (field >= `LED_SLOT_FIRST && field <= `LED_SLOT_LAST) begin
                    // slot lengths are trusted to cover ramps plus on-time
                    next_r.slotLength[led][3'(field - `LED_SLOT_FIRST)] = regWriteData;
                end
            end
        end

        // unmapped reads return zero
        next_r.readData = `RESET_BYTE;
        if (regRead) begin
            if (regAddr == `REG_PIN_SELECT) begin
                next_r.readData = {5'h00, r.pinSelect};
            end else if (regAddr == `REG_SEQ_ENABLE) begin
                next_r.readData = {2'h0, r.flashEnable, r.sinkEnable};
            end else if (regAddr == `REG_RAMP_UP) begin
                next_r.readData = {3'h0, r.rampUp};
            end else if (regAddr == `REG_RAMP_DOWN) begin
                next_r.readData = {3'h0, r.rampDown};
            end else if (block >= `LED_BLOCK_FIRST && block <= `LED_BLOCK_LAST) begin
                if (field == `LED_CURRENT) begin
                    next_r.readData = {4'h0, r.current[led]};
                end else if (field == `LED_DUTY) begin
                    next_r.readData = {3'h0, r.duty[led]};
                end else if (field == `LED_RAMP) begin
                    next_r.readData = {7'h00, r.rampSelect[led]};
                end else if (field == `LED_ON) begin
                    next_r.readData = r.onDuration[led];
                end else if (field >= `LED_SLOT_FIRST && field <= `LED_SLOT_LAST) begin
                    next_r.readData = r.slotLength[led][3'(field - `LED_SLOT_FIRST)];
                end else if (field == `LED_STATUS) begin
                    next_r.readData = {chLit[led], chSlot[led], chLevel[led]};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign regReadData = r.readData;
    assign pinDrive = r.pinDrive;
    assign pinSinkMode = r.pinSelect;
    assign pinSinkOn = chSinkOn;
    // code n sinks 2 mA + n * 2 mA, so 4 gives 10 mA
    assign pinSinkCode = chLevel;
endmodule

// ==== led_defs.svh ====
// offsets, field positions, reset values and timing counts of the LED sink sequencer
// assumes a 100 MHz clock and the plain register port of the top module
//
// What this block does
// - function-select bit turns pin into current sink
// - sink driven only while its enable bit set
// - PWM duty from 5-bit field, all ones full
// - 4-bit current code, 0100 gives 10 mA
// - sink current 2 to 20 mA, per LED
// - per-LED flash enable runs pattern in hardware
// - four slots plus period slot, on-time with ramps
// - ramp slopes shared, other settings per LED
// - ramp select: jump or step toward level
// - ramp step time 1 to 31 times 8 ms, code 0 steps like 1
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH

// ************************************************
// register offsets
// ************************************************
`define REG_PIN_SELECT 8'h00
`define REG_SEQ_ENABLE 8'h01
`define REG_RAMP_UP 8'h02
`define REG_RAMP_DOWN 8'h03
`define LED_BLOCK_FIRST 4'h1
`define LED_BLOCK_LAST 4'h3
`define LED_CURRENT 4'h0
`define LED_DUTY 4'h1
`define LED_RAMP 4'h2
`define LED_ON 4'h3
`define LED_SLOT_FIRST 4'h4
`define LED_SLOT_LAST 4'h8
`define LED_STATUS 4'h9

// ************************************************
// field positions and values
// ************************************************
`define SEQ_FLASH_LSB 3
`define CURRENT_MAX 4'h9
`define SLOT_PERIOD 3'h4
`define PWM_LAST 5'h1E
`define RESET_BYTE 8'h00

// ************************************************
// timing
// ************************************************
`define CLK_PERIOD_NS 10
`define TICK_MS 8
`define TICK_CYCLES (`TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define PWM_STEP_NS 80
`define PWM_STEP_CYCLES (`PWM_STEP_NS / `CLK_PERIOD_NS)

`endif

// ==== led_pkg.sv ====
// types shared by the LED sink sequencer and its channel
// assumes nothing beyond a SystemVerilog compiler
package led_pkg;
    typedef enum logic [2:0] {IDLE, RAMP_UP, ON_HOLD, RAMP_DOWN, DARK} seq_state_e;
    typedef logic [2:0][3:0] code_array_t;
    typedef logic [4:0][7:0] slot_array_t;

    typedef struct packed {
        seq_state_e state;
        logic [2:0] slot;
        logic [7:0] slotTimer;
        logic [7:0] phaseTimer;
        logic [4:0] stepTimer;
        logic [3:0] level;
        logic lit;
        logic sinkOn;
    } channel_s;

    typedef struct packed {
        logic [2:0] pinSelect;
        logic [2:0] sinkEnable;
        logic [2:0] flashEnable;
        logic [4:0] rampUp;
        logic [4:0] rampDown;
        logic [2:0][3:0] current;
        logic [2:0][4:0] duty;
        logic [2:0] rampSelect;
        logic [2:0][7:0] onDuration;
        logic [2:0][4:0][7:0] slotLength;
        logic [7:0] readData;
        logic [19:0] tickCount;
        logic tick;
        logic [3:0] pwmDiv;
        logic [4:0] pwmCount;
        logic [2:0] pinDrive;
    } top_s;
endpackage

// ==== led_channel_if.sv ====
// settings and status passed between the top module and one LED channel
// assumes one instance per channel, driven by the top module
interface led_channel_if;
    logic enable;
    logic run;
    logic tick;
    logic rampSelect;
    logic [3:0] target;
    logic [4:0] duty;
    logic [4:0] pwmCount;
    logic [4:0] rampUp;
    logic [4:0] rampDown;
    logic [7:0] onDuration;
    led_pkg::slot_array_t slotLength;
    logic sinkOn;
    logic lit;
    logic [3:0] level;
    logic [2:0] slot;

    modport top (output enable, run, tick, rampSelect, target, duty, pwmCount, rampUp,
        rampDown, onDuration, slotLength, input sinkOn, lit, level, slot);
    modport channel (input enable, run, tick, rampSelect, target, duty, pwmCount, rampUp,
        rampDown, onDuration, slotLength, output sinkOn, lit, level, slot);
endinterface

// ==== led_channel.sv ====
// one LED channel: flash sequencer, ramps and PWM gating of the current sink
// assumes settings arrive through led_channel_if, tick is one cycle per 8 ms
module led_channel (
    input wire logic clk,
    input wire logic reset,
    led_channel_if.channel ch
);
    import led_pkg::*;

    channel_s s;
    channel_s next_s;
    logic slotEnd;

    assign slotEnd = ({1'b0, s.slotTimer} + 9'h001) >= {1'b0, ch.slotLength[s.slot]};

    always_comb begin
        next_s = s;
        if (!ch.run) begin
            // steady mode: full target level, no pattern
            next_s.state = IDLE;
            next_s.slot = 3'h0;
            next_s.slotTimer = 8'h00;
            next_s.phaseTimer = 8'h00;
            next_s.stepTimer = 5'h00;
            next_s.level = ch.target;
            next_s.lit = 1'b1;
        end else if (ch.tick) begin
            if (s.state == IDLE || slotEnd) begin
                // slots 0..3 then period slot, wrapping
                next_s.slot = (s.state == IDLE || s.slot == `SLOT_PERIOD) ? 3'h0
                    : s.slot + 3'h1;
                next_s.slotTimer = 8'h00;
                next_s.phaseTimer = 8'h00;
                next_s.stepTimer = 5'h00;
                next_s.state = RAMP_UP;
                next_s.level = ch.rampSelect ? 4'h0 : ch.target;
                next_s.lit = 1'b1;
            end else begin
                next_s.slotTimer = s.slotTimer + 8'h01;
                unique case (s.state)
                    IDLE, DARK: begin
                    end
                    RAMP_UP: begin
                        if (s.level >= ch.target) begin
                            next_s.state = ON_HOLD;
                        // code n steps every n ticks; code 0 steps every tick
                        end else if (({1'b0, s.stepTimer} + 6'h01) >= {1'b0, ch.rampUp}) begin
                            next_s.level = s.level + 4'h1;
                            next_s.stepTimer = 5'h00;
                        end else begin
                            next_s.stepTimer = s.stepTimer + 5'h01;
                        end
                    end
                    ON_HOLD: begin
                        if (({1'b0, s.phaseTimer} + 9'h001) >= {1'b0, ch.onDuration}) begin
                            next_s.stepTimer = 5'h00;
                            next_s.state = ch.rampSelect ? RAMP_DOWN : DARK;
                            next_s.lit = ch.rampSelect;
                        end else begin
                            next_s.phaseTimer = s.phaseTimer + 8'h01;
                        end
                    end
                    RAMP_DOWN: begin
                        if (s.level == 4'h0) begin
                            next_s.state = DARK;
                            next_s.lit = 1'b0;
                        end else if (({1'b0, s.stepTimer} + 6'h01) >= {1'b0, ch.rampDown}) begin
                            next_s.level = s.level - 4'h1;
                            next_s.stepTimer = 5'h00;
                        end else begin
                            next_s.stepTimer = s.stepTimer + 5'h01;
                        end
                    end
                endcase
            end
        end
        // duty 31 never fails the compare, so all ones is full duty
        next_s.sinkOn = ch.enable && next_s.lit && (ch.pwmCount < ch.duty);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '{state: IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign ch.sinkOn = s.sinkOn;
    assign ch.lit = s.lit;
    assign ch.level = s.level;
    assign ch.slot = s.slot;
endmodule

// ==== led_sink_chk.sv ====
// concurrent checks on the ports of the LED sink sequencer
// assumes the plain register port and the register map of led_defs.svh
module led_sink_chk #(
    parameter logic [19:0] TICK_CYCLES = 20'hC3500
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic [2:0] gpioData,
    input wire logic [2:0] pinDrive,
    input wire logic [2:0] pinSinkMode,
    input wire logic [2:0] pinSinkOn,
    input wire led_pkg::code_array_t pinSinkCode
);
    import led_pkg::*;
    // ************************************************
    // shadow of the settings written by software
    // ************************************************
    logic [2:0] shSel, shEn, shFlash, gate, steady, full, dark;
    logic [2:0][3:0] shCur, expCode;
    logic [2:0][4:0] shDuty;
    logic [1:0] settle;
    always_ff @(posedge clk) begin
        if (reset) begin
            shSel <= '0;
            shEn <= '0;
            shFlash <= '0;
            shCur <= '0;
            shDuty <= '0;
            settle <= '0;
        end else begin
            settle <= regWrite ? 2'h0 : (settle == 2'h3 ? settle : settle + 2'h1);
            if (regWrite && regAddr == 8'h00) shSel <= regWriteData[2:0];
            if (regWrite && regAddr == 8'h01) begin
                shEn <= regWriteData[2:0];
                shFlash <= regWriteData[5:3];
            end
            for (int i = 0; i < 3; i++) begin
                if (regWrite && regAddr == 8'(8'h10 * (i + 1))) shCur[i] <= regWriteData[3:0];
                if (regWrite && regAddr == 8'(8'h10 * (i + 1) + 1)) shDuty[i] <= regWriteData[4:0];
            end
        end
    end
    // outputs lag the registers by up to two cycles, so checks wait for settle
    always_comb begin
        gate = shSel & shEn;
        steady = gate & ~shFlash;
        for (int i = 0; i < 3; i++) begin
            full[i] = steady[i] && shDuty[i] == 5'h1F;
            dark[i] = steady[i] && shDuty[i] == 5'h00;
            expCode[i] = (shCur[i] > 4'h9) ? 4'h9 : shCur[i];
        end
    end
    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_sink_gated: assert property (settle == 2'h3 |-> (pinSinkOn & ~gate) == 3'h0)
        else $error("sink conducting without select and enable");
    chk_full_duty: assert property (settle == 2'h3 |-> (full & ~pinSinkOn) == 3'h0)
        else $error("full duty sink not conducting");
    chk_zero_duty: assert property (settle == 2'h3 |-> (dark & pinSinkOn) == 3'h0)
        else $error("zero duty sink conducting");
    chk_code_follows: assert property (settle == 2'h3 |-> (steady[0] == 1'b0 || pinSinkCode[0] == expCode[0]) && (steady[1] == 1'b0 || pinSinkCode[1] == expCode[1]) && (steady[2] == 1'b0 || pinSinkCode[2] == expCode[2]))
        else $error("sink code differs from current setting");
    chk_code_range: assert property (pinSinkCode[0] <= 4'h9 && pinSinkCode[1] <= 4'h9 && pinSinkCode[2] <= 4'h9)
        else $error("sink code beyond 20 mA");
    chk_gpio_path: assert property (settle == 2'h3 && !$past(reset) |-> pinDrive == ($past(gpioData) & ~pinSinkMode))
        else $error("pin output not masked by sink mode");
    chk_mode_select: assert property (settle == 2'h3 |-> pinSinkMode == shSel)
        else $error("sink mode differs from pin select");
    chk_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) reset |=> pinSinkOn == 3'h0 && pinDrive == 3'h0 && pinSinkMode == 3'h0)
        else $error("outputs active after reset");
endmodule

bind led_current_sink_sequencer led_sink_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk),
    .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .gpioData(gpioData), .pinDrive(pinDrive),
    .pinSinkMode(pinSinkMode), .pinSinkOn(pinSinkOn), .pinSinkCode(pinSinkCode));

// ==== led_load_model.sv ====
// external LEDs on the three sink pins: current drawn in mA
// assumes code n sinks 2 + 2n mA while the sink conducts
module led_load_model (
    input wire logic [2:0] pinSinkOn,
    input wire led_pkg::code_array_t pinSinkCode,
    output logic [2:0][4:0] loadMa
);
    import led_pkg::*;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            loadMa[i] = pinSinkOn[i] ? 5'(5'h02 + 5'h02 * pinSinkCode[i]) : 5'h00;
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the LED sink sequencer
// assumes a short tick so that whole flash cycles fit in the run
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import led_pkg::*;
    localparam logic [19:0] TICK = 20'h00014;
    logic clk, reset, regWrite, regRead;
    logic [7:0] regAddr, regWriteData, regReadData;
    logic [2:0] gpioData, pinDrive, pinSinkMode, pinSinkOn;
    code_array_t pinSinkCode;
    logic [2:0][4:0] loadMa;
    int fails = 0, compares = 0, cyc = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    led_current_sink_sequencer #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .gpioData(gpioData), .pinDrive(pinDrive),
        .pinSinkMode(pinSinkMode), .pinSinkOn(pinSinkOn), .pinSinkCode(pinSinkCode));
    led_load_model u_load (.pinSinkOn(pinSinkOn), .pinSinkCode(pinSinkCode), .loadMa(loadMa));
    // ************************************************
    // bus and compare helpers
    // ************************************************
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic results();
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic regs_scn();
        logic [7:0] d;
        logic [7:0] addrs[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h28};
        foreach (addrs[i]) begin
            rd(addrs[i], d);
            check("reset value", 16'(d), 16'h0000);
        end
        wr(8'h02, 8'hFF);
        rd(8'h02, d);
        check("ramp step width", 16'(d), 16'h001F);
        wr(8'h40, 8'hFF);
        rd(8'h40, d);
        check("unmapped read", 16'(d), 16'h0000);
        wr(8'h02, 8'h00);
    endtask
    task automatic steady_scn();
        logic [3:0] e;
        wr(8'h00, 8'h07);
        wr(8'h11, 8'h1F);
        wr(8'h01, 8'h01);
        for (int c = 0; c < 16; c++) begin
            e = (c > 9) ? 4'h9 : 4'(c);
            wr(8'h10, 8'(c));
            settle();
            check("sink code", 16'(pinSinkCode[0]), 16'(e));
            check("load current", 16'(loadMa[0]), 16'(2 + 2 * e));
            check("full duty on", 16'(pinSinkOn[0]), 16'h0001);
        end
    endtask
    task automatic pwm_scn();
        int n;
        int duties[4] = '{0, 1, 16, 30};
        foreach (duties[i]) begin
            wr(8'h11, 8'(duties[i]));
            settle();
            n = 0;
            repeat (248) begin
                @(posedge clk);
                #1 n += int'(pinSinkOn[0]);
            end
            check("on cycles per frame", 16'(n), 16'(duties[i] * 8));
        end
        wr(8'h11, 8'h1F);
        wr(8'h01, 8'h00);
        settle();
        check("disabled sink", 16'(pinSinkOn), 16'h0000);
    endtask
    task automatic gpio_scn();
        wr(8'h00, 8'h00);
        gpioData <= 3'h5;
        settle();
        check("gpio drive", 16'(pinDrive), 16'h0005);
        check("sink mode", 16'(pinSinkMode), 16'h0000);
        wr(8'h00, 8'h02);
        gpioData <= 3'h7;
        settle();
        check("mixed drive", 16'(pinDrive), 16'h0005);
        check("mixed mode", 16'(pinSinkMode), 16'h0002);
        wr(8'h00, 8'h07);
        settle();
        check("sink drive", 16'(pinDrive), 16'h0000);
    endtask
    task automatic flash_scn(input int led, input bit ramp);
        logic [7:0] b, d;
        logic [3:0] prev;
        logic [3:0] eff;
        logic [2:0] q[$];
        int rise, t1, t2;
        b = 8'(16 * (led + 1));
        prev = 4'hF;
        rise = 0;
        t1 = 0;
        t2 = 0;
        wr(8'h02, 8'h02);
        wr(8'h03, 8'h00);
        wr(b + 8'h02, 8'(ramp));
        wr(b + 8'h03, 8'h02);
        // ramps plus on time take 11 ticks, inside every 12-tick slot
        for (int s = 4; s < 9; s++) wr(b + 8'(s), 8'h0C);
        wr(b, 8'h03);
        wr(8'h00, 8'h07);
        wr(8'h01, 8'(9 << led));
        repeat (750) begin
            rd(b + 8'h09, d);
            // a dark sink carries no current whatever its level
            eff = d[7] ? d[3:0] : 4'h0;
            if (q.size() == 0 || q[$] != d[6:4]) q.push_back(d[6:4]);
            if (eff > prev && int'(eff - prev) > rise) rise = int'(eff - prev);
            if (eff == 4'h1 && t1 == 0) t1 = cyc;
            if (eff == 4'h2 && t2 == 0) t2 = cyc;
            prev = eff;
        end
        wr(8'h01, 8'h00);
        check("slot changes seen", 16'(q.size() >= 6), 16'h0001);
        for (int i = 0; i < 6; i++) check("slot order", 16'(q[i]), 16'(i % 5));
        check("level rise", 16'(rise), ramp ? 16'h0001 : 16'h0003);
        if (ramp) check("ramp step time", 16'(t2 - t1), 16'(2 * TICK));
    endtask
    // ************************************************
    // main sequence and watchdog
    // ************************************************
    initial begin
        reset = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWriteData = 8'h00;
        gpioData = 3'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        regs_scn();
        steady_scn();
        pwm_scn();
        gpio_scn();
        flash_scn(0, 1'b1);
        flash_scn(1, 1'b0);
        flash_scn(2, 1'b1);
        results();
    end
    // whole run needs about 5700 cycles
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        results();
    end
endmodule
